// [dv/tb_top.sv]
// Self-checking bench for the interrupt source and mask block.
// Assumes uim_core on one 100 MHz clock and the host model beside it.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v, rnd;
  logic rts_pin, cts_pin, rx_ovr, rx_mis, par_e, frm_e, e_v;
  uim_pkg::uim_bus_acc_t pop, push;
  uim_pkg::uim_queue_t rxq, txq;
  logic [12:0] exp_src, exp_mask;
  // Accesses: strobe, size, pointer, at limit; and whether each errs
  logic [5:0] cs [6] = '{6'h32, 6'h2a, 6'h26, 6'h31, 6'h30, 6'h2c};
  bit ce [6] = '{1, 1, 0, 1, 0, 0};
  int num_errors = 0;
  int n_checks = 0;
  int seed = 42;
  int n_v;

  uim_core u_dut (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rts_pin(rts_pin), .cts_pin(cts_pin), .line_rx_overrun(rx_ovr),
    .line_rx_misalign(rx_mis), .parity_error(par_e),
    .frame_error(frm_e), .bus_pop(pop), .bus_push(push),
    .rx_queue(rxq), .tx_queue(txq), .irq(irq));
  uim_host u_host (.clock(clock), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ex,
      input logic er);
    u_host.xfer(1'b0, a, 32'h0, rd_v, e_v, n_v);
    chk(n_v, 32'h2);
    chk(rd_v, ex);
    chk({31'h0, e_v}, {31'h0, er});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic er);
    u_host.xfer(1'b1, a, d, rd_v, e_v, n_v);
    chk(n_v, 32'h2);
    chk({31'h0, e_v}, {31'h0, er});
  endtask

  // Raw sources read back, pin compared with the model
  task automatic chk_src;
    rd(12'h000, {19'h0, exp_src}, 1'b0);
    chk({31'h0, irq}, {31'h0, |(exp_src & ~exp_mask)});
  endtask

  // One cycle of stimulus, then check and clear the bit
  task automatic ev(input int b, input bit hit);
    @(negedge clock);
    {rx_ovr, rx_mis, par_e, frm_e} = 4'h0;
    pop = '0;
    push = '0;
    exp_src[b] = exp_src[b] | hit;
    chk_src();
    wr(12'h008, 32'h1 << b, 1'b0);
    exp_src[b] = 1'b0;
    chk_src();
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    num_errors++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    {rts_pin, cts_pin, rx_ovr, rx_mis, par_e, frm_e} = 6'h0;
    pop = '0;
    push = '0;
    // Empty at release gives no event; level below threshold
    rxq = '{full:1'b0, empty:1'b1, level:8'h0, threshold:8'h4};
    txq = rxq;
    exp_src = 13'h0;
    exp_mask = 13'h1fff;
    repeat (4) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    rd(12'h004, 32'h1fff, 1'b0);
    wr(12'h004, 32'h0, 1'b0);
    exp_mask = 13'h0;
    rts_pin = 1'b1;
    exp_src[12] = 1'b1;
    repeat (3) @(negedge clock);
    chk_src();
    {rts_pin, cts_pin} = 2'b01;
    exp_src[12:11] = 2'b01;
    repeat (3) @(negedge clock);
    chk_src();
    rx_ovr = 1'b1;
    ev(10, 1);
    rx_mis = 1'b1;
    ev(10, 1);
    par_e = 1'b1;
    ev(9, 1);
    frm_e = 1'b1;
    ev(8, 1);
    for (int i = 0; i < 12; i++) begin
      if (i % 2)
        push = uim_pkg::uim_bus_acc_t'(cs[i / 2]);
      else
        pop = uim_pkg::uim_bus_acc_t'(cs[i / 2]);
      ev(7 - i % 2, ce[i / 2]);
    end
    rxq.empty = 1'b0;
    rxq.level = 8'h4;
    ev(3, 1);
    rxq.level = 8'h5;
    ev(4, 1);
    rxq.full = 1'b1;
    ev(5, 1);
    txq.full = 1'b1;
    txq.empty = 1'b0;
    ev(2, 0);
    txq.full = 1'b0;
    ev(2, 1);
    txq.level = 8'h5;
    ev(1, 1);
    txq.empty = 1'b1;
    ev(0, 1);
    // Latched events stay while masks change
    par_e = 1'b1;
    frm_e = 1'b1;
    @(negedge clock);
    par_e = 1'b0;
    frm_e = 1'b0;
    exp_src[9:8] = 2'b11;
    repeat (6) begin
      rnd = $random(seed);
      wr(12'h004, rnd, 1'b0);
      exp_mask = rnd[12:0];
      rd(12'h004, {19'h0, exp_mask}, 1'b0);
      chk_src();
    end
    wr(12'h000, 32'hffff, 1'b0);
    chk_src();
    rd(12'h008, 32'h0, 1'b0);
    rd(12'h00c, 32'h0, 1'b1);
    wr(12'h00c, 32'h0, 1'b1);
    wr(12'h004, 32'h0, 1'b0);
    exp_mask = 13'h0;
    wr(12'h008, 32'hffff_ffff, 1'b0);
    exp_src[10:0] = 11'h0;
    chk_src();
    // Event on the clearing edge only; set must win
    fork
      wr(12'h008, 32'h100, 1'b0);
      begin
        repeat (2) @(negedge clock);
        frm_e = 1'b1;
        @(negedge clock);
        frm_e = 1'b0;
      end
    join
    exp_src[8] = 1'b1;
    chk_src();
    // Mid-run reset: masks set again, queue edges raised anew
    rst_b = 1'b0;
    @(negedge clock);
    rst_b = 1'b1;
    exp_src = 13'h083a;
    exp_mask = 13'h1fff;
    rd(12'h004, 32'h1fff, 1'b0);
    chk_src();
    finish_test();
  end
endmodule

// [dv/uim_host.sv]
// Bus host model: runs one register transfer at a time.
// Assumes the block answers with pready within a few cycles.
module uim_host (
  input wire logic clock,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e,
      output int c);
    int n;
    @(negedge clock);
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge clock);
    penable = 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    c = n;
    @(negedge clock);
    psel = 1'b0;
    penable = 1'b0;
    // Released lines show the inverse so stale values never pass
    paddr = ~a;
    pwdata = ~d;
  endtask
endmodule

// [rtl/uim_cfg.svh]
// Constants for the UART interrupt source and mask block.
// Assumes inclusion by its bare name from the package and the block files.
`ifndef UIM_CFG_SVH
`define UIM_CFG_SVH

// Register offsets on the peripheral bus
`define UIM_ADDR_W 12
`define UIM_OFS_SRC 12'h000
`define UIM_OFS_MASK 12'h004
`define UIM_OFS_CLR 12'h008

// Source bit positions
`define UIM_NSRC 13
`define UIM_NEVT 11
`define UIM_B_RTS 12
`define UIM_B_CTS 11
`define UIM_B_RXPUSH 10
`define UIM_B_PARITY 9
`define UIM_B_FRAME 8
`define UIM_B_POP 7
`define UIM_B_PUSH 6
`define UIM_B_RXFULL 5
`define UIM_B_RXTHR 4
`define UIM_B_RXNE 3
`define UIM_B_TXNF 2
`define UIM_B_TXTHR 1
`define UIM_B_TXDR 0

// Reset values
`define UIM_MASK_RST 13'h1fff
`define UIM_SRC_RST 11'h000

// Queue level and threshold width in bits
`define UIM_LVL_W 8

`endif

// [rtl/uim_core.sv]
// Interrupt source, mask and clear registers of the UART, with the pin.
// Assumes the APB host on the same clock and queue logic reporting status.
`include "uim_cfg.svh"

module uim_core #(
  parameter int ADDR_W = `UIM_ADDR_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rts_pin,
  input wire logic cts_pin,
  input wire logic line_rx_overrun,
  input wire logic line_rx_misalign,
  input wire logic parity_error,
  input wire logic frame_error,
  input wire uim_pkg::uim_bus_acc_t bus_pop,
  input wire uim_pkg::uim_bus_acc_t bus_push,
  input wire uim_pkg::uim_queue_t rx_queue,
  input wire uim_pkg::uim_queue_t tx_queue,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Modem line synchronisers

  logic rts_meta_q;
  logic rts_sync_q;
  logic cts_meta_q;
  logic cts_sync_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rts_meta_q <= 1'b0;
      rts_sync_q <= 1'b0;
      cts_meta_q <= 1'b0;
      cts_sync_q <= 1'b0;
    end else begin
      rts_meta_q <= rts_pin;
      rts_sync_q <= rts_meta_q;
      cts_meta_q <= cts_pin;
      cts_sync_q <= cts_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue edge detection

  logic rx_full_q;
  logic rx_above_q;
  logic rx_empty_q;
  logic tx_full_q;
  logic tx_above_q;
  logic tx_empty_q;
  logic rx_above;
  logic tx_above;

  assign rx_above = rx_queue.level > rx_queue.threshold;
  assign tx_above = tx_queue.level > tx_queue.threshold;

  // Empty history starts high so an idle queue raises nothing at reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_full_q <= 1'b0;
      rx_above_q <= 1'b0;
      rx_empty_q <= 1'b1;
      tx_full_q <= 1'b0;
      tx_above_q <= 1'b0;
      tx_empty_q <= 1'b1;
    end else begin
      rx_full_q <= rx_queue.full;
      rx_above_q <= rx_above;
      rx_empty_q <= rx_queue.empty;
      tx_full_q <= tx_queue.full;
      tx_above_q <= tx_above;
      tx_empty_q <= tx_queue.empty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus access errors

  logic pop_misalign;
  logic push_misalign;
  logic pop_err;
  logic push_err;

  // Half words also need an even pointer
  assign pop_misalign =
    ((bus_pop.size == uim_pkg::UIM_SZ_WORD) && (bus_pop.byte_ptr != 2'h0)) ||
    ((bus_pop.size == uim_pkg::UIM_SZ_HALF) && bus_pop.byte_ptr[0]);
  assign push_misalign =
    ((bus_push.size == uim_pkg::UIM_SZ_WORD) && (bus_push.byte_ptr != 2'h0)) ||
    ((bus_push.size == uim_pkg::UIM_SZ_HALF) && bus_push.byte_ptr[0]);
  assign pop_err = bus_pop.strobe & (bus_pop.at_limit | pop_misalign);
  assign push_err = bus_push.strobe & (bus_push.at_limit | push_misalign);

  ////////////////////////////////////////////////////////////////////////////
  // Event vector

  logic [`UIM_NEVT-1:0] evt;

  assign evt[`UIM_B_RXPUSH] = line_rx_overrun | line_rx_misalign;
  assign evt[`UIM_B_PARITY] = parity_error;
  assign evt[`UIM_B_FRAME] = frame_error;
  assign evt[`UIM_B_POP] = pop_err;
  assign evt[`UIM_B_PUSH] = push_err;
  assign evt[`UIM_B_RXFULL] = rx_queue.full & ~rx_full_q;
  assign evt[`UIM_B_RXTHR] = rx_above & ~rx_above_q;
  assign evt[`UIM_B_RXNE] = ~rx_queue.empty & rx_empty_q;
  assign evt[`UIM_B_TXNF] = ~tx_queue.full & tx_full_q;
  assign evt[`UIM_B_TXTHR] = tx_above & ~tx_above_q;
  assign evt[`UIM_B_TXDR] = tx_queue.empty & ~tx_empty_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic acc_w;
  logic wr_w;
  logic hit_src;
  logic hit_mask;
  logic hit_clr;
  logic hit_any;
  logic [`UIM_NEVT-1:0] clr_w;

  // One wait state gives registered read data
  assign acc_w = psel & penable & ~pready;
  assign wr_w = acc_w & pwrite;
  assign hit_src = paddr == `UIM_OFS_SRC;
  assign hit_mask = paddr == `UIM_OFS_MASK;
  assign hit_clr = paddr == `UIM_OFS_CLR;
  assign hit_any = hit_src | hit_mask | hit_clr;
  // Modem bits have no clear path at all
  assign clr_w = (wr_w & hit_clr) ? pwdata[`UIM_NEVT-1:0] :
                 `UIM_SRC_RST;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags

  logic [`UIM_NEVT-1:0] evt_q;

  for (genvar i = 0; i < `UIM_NEVT; i++) begin : g_flag
    uim_flag_cell u_cell (
      .clock(clock),
      .rst_b(rst_b),
      .set(evt[i]),
      .clr(clr_w[i]),
      .flag_q(evt_q[i])
    );
  end

  logic [`UIM_NSRC-1:0] src_w;

  assign src_w = {rts_sync_q, cts_sync_q, evt_q};

  ////////////////////////////////////////////////////////////////////////////
  // Mask register and bus answer

  logic [`UIM_NSRC-1:0] mask_q;
  logic [`UIM_NSRC-1:0] mask_d;
  logic [31:0] rdata_d;
  logic irq_d;

  assign mask_d = (wr_w & hit_mask) ? pwdata[`UIM_NSRC-1:0] : mask_q;
  // Reads show the raw sources, never the gated ones
  assign rdata_d = hit_src ? {19'h00000, src_w} :
                   hit_mask ? {19'h00000, mask_q} : 32'h00000000;
  assign irq_d = |(src_w & ~mask_q);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= `UIM_MASK_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      mask_q <= mask_d;
      prdata <= (acc_w & ~pwrite) ? rdata_d : 32'h00000000;
      pready <= acc_w;
      pslverr <= acc_w & ~hit_any;
      irq <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_rts_live;
    $past(rst_b, 2) |-> src_w[`UIM_B_RTS] == $past(rts_pin, 2);
  endproperty
  a_rts_live: assert property (p_rts_live)
    else $error("rts source bit does not follow pin");

  property p_cts_live;
    $rose(cts_pin) ##1 cts_pin |=> src_w[`UIM_B_CTS];
  endproperty
  a_cts_live: assert property (p_cts_live)
    else $error("cts source bit missed a rise");

  property p_rxpush_set;
    (line_rx_overrun | line_rx_misalign) |=> src_w[`UIM_B_RXPUSH];
  endproperty
  a_rxpush_set: assert property (p_rxpush_set)
    else $error("line receive error not latched");

  property p_parity_set;
    parity_error |=> src_w[`UIM_B_PARITY];
  endproperty
  a_parity_set: assert property (p_parity_set)
    else $error("parity error not latched");

  property p_frame_hold;
    frame_error ##1 !(wr_w && hit_clr && pwdata[`UIM_B_FRAME])
      |=> src_w[`UIM_B_FRAME];
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame error lost before a clear");

  property p_push_misalign;
    bus_push.strobe && bus_push.size == uim_pkg::UIM_SZ_WORD &&
      bus_push.byte_ptr != 2'h0 |=> src_w[`UIM_B_PUSH];
  endproperty
  a_push_misalign: assert property (p_push_misalign)
    else $error("misaligned word push not flagged");

  property p_pop_underrun;
    bus_pop.strobe && bus_pop.at_limit |=> src_w[`UIM_B_POP];
  endproperty
  a_pop_underrun: assert property (p_pop_underrun)
    else $error("underrun pop not flagged");

  property p_rx_full;
    $rose(rx_queue.full) |=> src_w[`UIM_B_RXFULL];
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("receive full not latched");

  property p_rx_nonempty;
    $fell(rx_queue.empty) |=> src_w[`UIM_B_RXNE];
  endproperty
  a_rx_nonempty: assert property (p_rx_nonempty)
    else $error("receive nonempty not latched");

  property p_tx_drained;
    $rose(tx_queue.empty) |=> src_w[`UIM_B_TXDR];
  endproperty
  a_tx_drained: assert property (p_tx_drained)
    else $error("transmit empty not latched");

  property p_read_raw;
    acc_w && !pwrite && hit_src |=> prdata == {19'h00000, $past(src_w)};
  endproperty
  a_read_raw: assert property (p_read_raw)
    else $error("source read differs from raw bits");

  property p_mask_write;
    wr_w && hit_mask |=> mask_q == $past(pwdata[`UIM_NSRC-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_irq_gate;
    ##1 irq == $past(|(src_w & ~mask_q));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt pin not the gated sources");

  property p_clear_bit;
    wr_w && hit_clr && pwdata[`UIM_B_PARITY] && !parity_error
      |=> !src_w[`UIM_B_PARITY];
  endproperty
  a_clear_bit: assert property (p_clear_bit)
    else $error("parity bit survived its clear");

  property p_set_wins;
    wr_w && hit_clr && pwdata[`UIM_B_FRAME] && frame_error
      |=> src_w[`UIM_B_FRAME];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost in clearing cycle");

  property p_push_overrun;
    bus_push.strobe && bus_push.at_limit |=> src_w[`UIM_B_PUSH];
  endproperty
  a_push_overrun: assert property (p_push_overrun)
    else $error("overrun push not flagged");

  property p_rx_thr;
    $rose(rx_queue.level > rx_queue.threshold) |=> src_w[`UIM_B_RXTHR];
  endproperty
  a_rx_thr: assert property (p_rx_thr)
    else $error("receive threshold crossing not latched");

  property p_tx_notfull;
    $fell(tx_queue.full) |=> src_w[`UIM_B_TXNF];
  endproperty
  a_tx_notfull: assert property (p_tx_notfull)
    else $error("transmit leaving full not latched");

  property p_tx_thr;
    $rose(tx_queue.level > tx_queue.threshold) |=> src_w[`UIM_B_TXTHR];
  endproperty
  a_tx_thr: assert property (p_tx_thr)
    else $error("transmit threshold crossing not latched");

  c_irq_rise: cover property ($rose(irq));
  c_frame_clear: cover property (
    src_w[`UIM_B_FRAME] ##1 (wr_w && hit_clr) ##1 !src_w[`UIM_B_FRAME]);
  c_push_misalign: cover property (bus_push.strobe && push_misalign);
  c_mask_open: cover property (wr_w && hit_mask && pwdata[3:0] == 4'h0);

endmodule

// [rtl/uim_flag_cell.sv]
// One sticky event flag with write-one clear.
// Assumes set and clear come from logic on the same clock.
module uim_flag_cell (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic set,
  input wire logic clr,
  output logic flag_q
);

  logic flag_d;

  // Set beats clear so an event in the clearing cycle survives
  assign flag_d = set | (flag_q & ~clr);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// [rtl/uim_pkg.sv]
// Types shared by the interrupt source and mask block.
// Assumes uim_cfg.svh is on the include path.
`include "uim_cfg.svh"

package uim_pkg;

  // Width of one bus access into a data queue
  typedef enum logic [1:0] {
    UIM_SZ_BYTE,
    UIM_SZ_HALF,
    UIM_SZ_WORD
  } uim_size_t;

  // One bus access to a data queue, reported by the queue logic
  typedef struct packed {
    logic strobe;
    uim_size_t size;
    logic [1:0] byte_ptr;
    logic at_limit;
  } uim_bus_acc_t;

  // State of one data queue
  typedef struct packed {
    logic full;
    logic empty;
    logic [`UIM_LVL_W-1:0] level;
    logic [`UIM_LVL_W-1:0] threshold;
  } uim_queue_t;

endpackage
